// ==== logic/regmap_pkg.sv ====
package regmap_pkg;

	// ------------------------------------------------------------
	// Register numbers on the link
	// ------------------------------------------------------------
	localparam logic [15:0] OP_STATE_ADDR   = 16'h07D6;
	localparam logic [15:0] SUPP_STATE_ADDR = 16'h07D7;
	localparam logic [15:0] GROUP0_BASE     = 16'h9C40;
	localparam logic [15:0] GROUP1_BASE     = 16'hA028;
	localparam logic [15:0] GROUP2_BASE     = 16'hA410;
	localparam logic [15:0] LOCK_ADDR       = 16'hABE1;
	localparam logic [15:0] CODE_ADDR       = 16'hABE2;

	// ------------------------------------------------------------
	// Function and exception codes
	// ------------------------------------------------------------
	localparam logic [7:0] FUNC_READ   = 8'h03;
	localparam logic [7:0] FUNC_WRITE  = 8'h06;
	localparam logic [7:0] EXC_FUNC    = 8'h01;
	localparam logic [7:0] EXC_ADDR    = 8'h02;
	localparam logic [7:0] EXC_VALUE   = 8'h03;
	localparam logic [7:0] EXC_REFUSED = 8'h04;

	// ------------------------------------------------------------
	// Field positions of the state words
	// ------------------------------------------------------------
	localparam int unsigned RUN_BIT       = 0;
	localparam int unsigned PANEL_SRC_BIT = 1;
	localparam int unsigned BLOCKED_BIT   = 2;
	localparam int unsigned RESTART_BIT   = 3;
	localparam int unsigned COUNT_LSB     = 4;
	localparam int unsigned CRC_BIT       = 7;
	localparam int unsigned FAULT_LSB     = 8;
	localparam int unsigned WARN_BIT      = 13;
	localparam int unsigned DIR_BIT       = 14;
	localparam int unsigned IDENT_BIT     = 15;
	localparam int unsigned DRYING_BIT    = 1;

	// ------------------------------------------------------------
	// Reset values, limits and defaults
	// ------------------------------------------------------------
	localparam logic        LOCK_RESET        = 1'b0;
	localparam logic        CODE_OK_RESET     = 1'b0;
	localparam logic [15:0] LOCK_VALUE_MAX    = 16'h0001;
	localparam int unsigned PARAM_COUNT_DEF   = 64;
	localparam int unsigned STOP_ONLY_DEF     = 16;
	localparam int unsigned WINDOW_SIZE       = 1000;
	localparam logic [15:0] PARAM_MAX_DEF     = 16'h7FFF;
	localparam logic [15:0] ACCESS_CODE_DEF   = 16'h0000;

	// Source of the answer word
	localparam logic [2:0] K_OP   = 3'h0;
	localparam logic [2:0] K_SUPP = 3'h1;
	localparam logic [2:0] K_MEM  = 3'h2;
	localparam logic [2:0] K_LOCK = 3'h3;
	localparam logic [2:0] K_ZERO = 3'h4;
	localparam logic [2:0] K_ECHO = 3'h5;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MEM  = 3'b010,
		ST_RESP = 3'b100
	} seq_state_t;

	function automatic logic window_hit(input logic [15:0] addr, input logic [15:0] base,
	                                    input int unsigned count);
		logic [16:0] lim;
		lim = {1'b0, base} + 17'(count);
		return ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < lim);
	endfunction

endpackage

// ==== logic/param_mem_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface param_mem_if #(
	parameter int unsigned AW = 8
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [15:0]   wdata;
	logic [AW-1:0] raddr;
	logic [15:0]   rdata;

	modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ==== logic/param_store.sv ====
`timescale 1ns/1ps
`default_nettype none

module param_store #(
	parameter int unsigned AW = 8
) (
	input  wire logic       clk,
	input  wire logic       rst,
	param_mem_if.store      port
);
	logic [15:0] mem [0:(2**AW)-1];
	logic [15:0] rdata_q;

	// Storage is not cleared; the drive loads real values after power-up
	always_ff @(posedge clk) begin
		if (port.we) begin
			mem[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= mem[port.raddr];
		end
	end

	assign port.rdata = rdata_q;
endmodule

`default_nettype wire

// ==== logic/drive_status_param_regmap.sv ====
`timescale 1ns/1ps
`default_nettype none

// Contract
// - state bit 0 set while running
// - bit 1 set when panel setpoint active
// - bit 2 set while drive blocked
// - bit 3 ready to restart after clear
// - bits 4-6 restart count or stage
// - bit 7 storage checksum error
// - bits 8-12 fault code, zero none
// - bit 13 zero failure, one warning
// - bit 14 direction, one is leftward
// - bit 15 set during identification run
// - supplementary bit 1 during motor drying
// - group 0 read-only at 40000 plus index
// - group 1 read/write at 41000 plus index
// - group 2 read/write at 42000 plus index
// - writes refused while change lock set
// - protected writes need matching access code
// - some parameters writable only when stopped
// - bad function code answers exception 1
// - unknown register answers exception 2
// - out-of-range write answers exception 3
// - no reply after transfer error
module drive_status_param_regmap
	import regmap_pkg::*;
#(
	parameter int unsigned PARAM_COUNT     = PARAM_COUNT_DEF,
	parameter int unsigned STOP_ONLY_COUNT = STOP_ONLY_DEF,
	parameter logic [15:0] PARAM_MAX       = PARAM_MAX_DEF,
	parameter logic [15:0] ACCESS_CODE     = ACCESS_CODE_DEF,
	localparam int unsigned IDX_W          = $clog2(PARAM_COUNT)
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             req_valid,
	output logic                  req_ready,
	input  wire logic [7:0]       req_func,
	input  wire logic [15:0]      req_addr,
	input  wire logic [15:0]      req_data,
	input  wire logic             req_xfer_err,
	output logic                  rsp_valid,
	input  wire logic             rsp_ready,
	output logic                  rsp_exc,
	output logic [7:0]            rsp_func,
	output logic [15:0]           rsp_data,
	input  wire logic             drive_running,
	input  wire logic             panel_setpoint,
	input  wire logic             drive_blocked,
	input  wire logic             restart_ready,
	input  wire logic [2:0]       restart_count,
	input  wire logic             eeprom_crc_err,
	input  wire logic [4:0]       fault_code,
	input  wire logic             fault_is_warning,
	input  wire logic             dir_left,
	input  wire logic             ident_active,
	input  wire logic             drying_active,
	input  wire logic             code_protect,
	input  wire logic             upd_valid,
	output logic                  upd_ready,
	input  wire logic [1:0]       upd_group,
	input  wire logic [IDX_W-1:0] upd_index,
	input  wire logic [15:0]      upd_data,
	output logic                  wr_event,
	output logic [1:0]            wr_group,
	output logic [IDX_W-1:0]      wr_index,
	output logic [15:0]           wr_value,
	output logic                  param_lock
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (PARAM_COUNT < 2 || PARAM_COUNT > WINDOW_SIZE) begin : g_bad_count
		$error("PARAM_COUNT must lie between 2 and the window size");
	end
	if (STOP_ONLY_COUNT > PARAM_COUNT) begin : g_bad_stop
		$error("STOP_ONLY_COUNT must not exceed PARAM_COUNT");
	end

	// ------------------------------------------------------------
	// State words
	// ------------------------------------------------------------
	logic [15:0] op_word;
	logic [15:0] supp_word;

	assign op_word = {ident_active, dir_left, fault_is_warning, fault_code, eeprom_crc_err,
	                  restart_count, restart_ready, drive_blocked, panel_setpoint,
	                  drive_running};
	assign supp_word = {14'h0000, drying_active, 1'b0};

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	seq_state_t        state_q;
	seq_state_t        state_d;
	logic              lock_q;
	logic              code_ok_q;
	logic              exc_q;
	logic [7:0]        exc_code_q;
	logic [2:0]        kind_q;
	logic [7:0]        func_q;
	logic [15:0]       echo_q;
	logic              rsp_exc_q;
	logic [7:0]        rsp_func_q;
	logic [15:0]       rsp_data_q;
	logic              wr_event_q;
	logic [1:0]        wr_group_q;
	logic [IDX_W-1:0]  wr_index_q;
	logic [15:0]       wr_value_q;

	wire logic        accept    = req_valid && req_ready;
	wire logic        take      = accept && !req_xfer_err;
	wire logic        is_read   = req_func == FUNC_READ;
	wire logic        is_write  = req_func == FUNC_WRITE;
	wire logic        hit_op    = req_addr == OP_STATE_ADDR;
	wire logic        hit_supp  = req_addr == SUPP_STATE_ADDR;
	wire logic        hit_lock  = req_addr == LOCK_ADDR;
	wire logic        hit_code  = req_addr == CODE_ADDR;
	wire logic        hit_g0    = window_hit(req_addr, GROUP0_BASE, PARAM_COUNT);
	wire logic        hit_g1    = window_hit(req_addr, GROUP1_BASE, PARAM_COUNT);
	wire logic        hit_g2    = window_hit(req_addr, GROUP2_BASE, PARAM_COUNT);
	wire logic        hit_param = hit_g0 || hit_g1 || hit_g2;
	wire logic        hit_rw    = hit_g1 || hit_g2;
	wire logic        known     = hit_op || hit_supp || hit_lock || hit_code || hit_param;
	wire logic [15:0] off0      = req_addr - GROUP0_BASE;
	wire logic [15:0] off1      = req_addr - GROUP1_BASE;
	wire logic [15:0] off2      = req_addr - GROUP2_BASE;
	wire logic [15:0] sel_off   = hit_g0 ? off0 : (hit_g1 ? off1 : off2);
	wire logic [1:0]  sel_group = hit_g0 ? 2'h0 : (hit_g1 ? 2'h1 : 2'h2);
	wire logic [IDX_W-1:0] sel_idx = sel_off[IDX_W-1:0];

	// Writing to a read-only word is reported as an unknown register
	wire logic bad_func  = !is_read && !is_write;
	wire logic bad_addr  = !known || (is_write && (hit_op || hit_supp || hit_g0));
	wire logic bad_value = is_write && ((hit_lock && req_data > LOCK_VALUE_MAX) ||
	                                    (hit_rw && req_data > PARAM_MAX));
	wire logic lock_deny = hit_rw && lock_q;
	wire logic code_deny = hit_rw && code_protect && !code_ok_q;
	wire logic stop_deny = hit_g1 && drive_running && (sel_off < 16'(STOP_ONLY_COUNT));
	wire logic refused   = is_write && (lock_deny || code_deny || stop_deny);

	wire logic [7:0] exc_code = bad_func  ? EXC_FUNC  :
	                            bad_addr  ? EXC_ADDR  :
	                            bad_value ? EXC_VALUE : EXC_REFUSED;
	wire logic       any_exc  = bad_func || bad_addr || bad_value || refused;
	wire logic       ok_write = take && is_write && !any_exc;
	wire logic       mem_we   = ok_write && hit_rw;

	wire logic [2:0] kind = is_write ? K_ECHO :
	                        hit_op   ? K_OP   :
	                        hit_supp ? K_SUPP :
	                        hit_lock ? K_LOCK :
	                        hit_code ? K_ZERO : K_MEM;

	// ------------------------------------------------------------
	// Parameter storage
	// ------------------------------------------------------------
	param_mem_if #(.AW(IDX_W + 2)) mem_bus ();

	param_store #(.AW(IDX_W + 2)) u_store (
		.clk  (clk),
		.rst  (rst),
		.port (mem_bus.store)
	);

	// Link writes win the single write port; the drive side waits one cycle
	assign upd_ready     = !mem_we;
	assign mem_bus.we    = mem_we || upd_valid;
	assign mem_bus.waddr = mem_we ? {sel_group, sel_idx} : {upd_group, upd_index};
	assign mem_bus.wdata = mem_we ? req_data : upd_data;
	assign mem_bus.raddr = {sel_group, sel_idx};

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	wire logic [15:0] word_mux = (kind_q == K_OP)   ? op_word                 :
	                             (kind_q == K_SUPP) ? supp_word               :
	                             (kind_q == K_LOCK) ? {15'h0000, lock_q}      :
	                             (kind_q == K_MEM)  ? mem_bus.rdata           :
	                             (kind_q == K_ECHO) ? echo_q : 16'h0000;
	wire logic [15:0] rsp_data_d = exc_q ? {8'h00, exc_code_q} : word_mux;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					state_d = ST_MEM;
				end
			end
			ST_MEM: begin
				state_d = ST_RESP;
			end
			ST_RESP: begin
				if (rsp_ready) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			exc_q      <= 1'b0;
			exc_code_q <= 8'h00;
			kind_q     <= K_ZERO;
			func_q     <= 8'h00;
			echo_q     <= 16'h0000;
		end else if (take) begin
			exc_q      <= any_exc;
			exc_code_q <= exc_code;
			kind_q     <= kind;
			func_q     <= req_func;
			echo_q     <= req_data;
		end
	end

	// Status is sampled one cycle after the request, together with memory data
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_exc_q  <= 1'b0;
			rsp_func_q <= 8'h00;
			rsp_data_q <= 16'h0000;
		end else if (state_q == ST_MEM) begin
			rsp_exc_q  <= exc_q;
			rsp_func_q <= func_q;
			rsp_data_q <= rsp_data_d;
		end
	end

	// ------------------------------------------------------------
	// Lock, access code and write event
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_q    <= LOCK_RESET;
			code_ok_q <= CODE_OK_RESET;
		end else if (ok_write && hit_lock) begin
			lock_q <= req_data[0];
		end else if (ok_write && hit_code) begin
			code_ok_q <= req_data == ACCESS_CODE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_event_q <= 1'b0;
			wr_group_q <= 2'h0;
			wr_index_q <= '0;
			wr_value_q <= 16'h0000;
		end else begin
			wr_event_q <= mem_we;
			if (mem_we) begin
				wr_group_q <= sel_group;
				wr_index_q <= sel_idx;
				wr_value_q <= req_data;
			end
		end
	end

	assign req_ready  = state_q == ST_IDLE;
	assign rsp_valid  = state_q == ST_RESP;
	assign rsp_exc    = rsp_exc_q;
	assign rsp_func   = rsp_func_q;
	assign rsp_data   = rsp_data_q;
	assign wr_event   = wr_event_q;
	assign wr_group   = wr_group_q;
	assign wr_index   = wr_index_q;
	assign wr_value   = wr_value_q;
	assign param_lock = lock_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	op_word_a: assert property ((state_q == ST_MEM) && !exc_q && (kind_q == K_OP)
		|=> rsp_data_q == {$past(ident_active), $past(dir_left), $past(fault_is_warning),
		                   $past(fault_code), $past(eeprom_crc_err), $past(restart_count),
		                   $past(restart_ready), $past(drive_blocked), $past(panel_setpoint),
		                   $past(drive_running)})
		else $error("operating state word wrong");
	supp_word_a: assert property ((state_q == ST_MEM) && !exc_q && (kind_q == K_SUPP)
		|=> rsp_data_q == {14'h0000, $past(drying_active), 1'b0})
		else $error("supplementary word wrong");
	g0_readonly_a: assert property (take && is_write && hit_g0
		|-> !mem_bus.we[*1] ##2 (rsp_exc && rsp_data == {8'h00, EXC_ADDR}))
		else $error("group 0 write not refused");
	g1_write_a: assert property (take && is_write && hit_rw && !lock_q && !code_deny
		&& !stop_deny && (req_data <= PARAM_MAX) |-> mem_we ##1 wr_event)
		else $error("accepted parameter write lost");
	lock_block_a: assert property (take && is_write && hit_rw && lock_q
		|-> !mem_we ##2 (rsp_exc && rsp_valid))
		else $error("write passed the lock");
	code_block_a: assert property (take && is_write && hit_rw && code_protect && !code_ok_q
		|-> !mem_we)
		else $error("write passed the access code");
	stop_only_a: assert property (take && is_write && hit_g1 && drive_running
		&& (sel_off < 16'(STOP_ONLY_COUNT)) |-> !mem_we)
		else $error("stop-only write while running");

	func_exc_a: assert property (take && bad_func
		|-> ##2 (rsp_valid && rsp_exc && rsp_data == {8'h00, EXC_FUNC}))
		else $error("bad function not answered with 1");

	addr_exc_a: assert property (take && !bad_func && !known
		|-> ##2 (rsp_valid && rsp_exc && rsp_data == {8'h00, EXC_ADDR}))
		else $error("unknown register not answered with 2");

	value_exc_a: assert property (take && is_write && hit_rw && (req_data > PARAM_MAX)
		|-> ##2 (rsp_exc && rsp_data == {8'h00, EXC_VALUE}))
		else $error("out of range value not answered with 3");

	xfer_drop_a: assert property (accept && req_xfer_err
		|=> (state_q == ST_IDLE) && !rsp_valid)
		else $error("reply after transfer error");

	read_op_c:   cover property (take && is_read && hit_op ##2 rsp_valid);
	write_ok_c:  cover property (mem_we ##1 wr_event);
	exc_c:       cover property (rsp_valid && rsp_exc);
	xfer_drop_c: cover property (accept && req_xfer_err);
endmodule

`default_nettype wire

// ==== sim/link_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module link_master (
	input  wire logic        clk,
	input  wire logic        req_ready,
	input  wire logic        rsp_valid,
	input  wire logic        rsp_exc,
	input  wire logic [7:0]  rsp_func,
	input  wire logic [15:0] rsp_data,
	output logic             req_valid,
	output logic [7:0]       req_func,
	output logic [15:0]      req_addr,
	output logic [15:0]      req_data,
	output logic             req_xfer_err,
	output logic             rsp_ready
);
	initial begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_data = 16'h0000;
		req_xfer_err = 1'b0;
		rsp_ready = 1'b0;
	end

	// ------------------------------------------------------------
	// One request at a time, entered just after a rising edge
	// ------------------------------------------------------------
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
	                    input logic e, input int stall, output logic x, output logic [7:0] rf,
	                    output logic [15:0] rd, output int lat, output logic rdy);
		x = 1'bx;
		rf = 8'hXX;
		rd = 16'hXXXX;
		lat = 1;
		req_valid = 1'b1;
		req_func = f;
		req_addr = a;
		req_data = d;
		req_xfer_err = e;
		while (req_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		// Released lines show the inverse so a stale sample cannot pass
		req_valid = 1'b0;
		req_func = ~f;
		req_addr = ~a;
		req_data = ~d;
		req_xfer_err = ~e;
		rdy = req_ready;
		while (rsp_valid !== 1'b1 && lat < 8) begin
			@(posedge clk);
			#1;
			lat++;
		end
		if (lat == 8)
			lat = 0;
		else begin
			repeat (stall) begin
				@(posedge clk);
				#1;
			end
			rsp_ready = 1'b1;
			x = rsp_exc;
			rf = rsp_func;
			rd = rsp_data;
			@(posedge clk);
			#1;
			rsp_ready = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// ==== sim/drive_status_param_regmap_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module drive_status_param_regmap_tb;
	import regmap_pkg::*;

	localparam logic [15:0] CODE = 16'h1234;

	logic        clk = 1'b0, rst = 1'b1, req_valid, req_ready, req_xfer_err, rsp_valid, rsp_ready;
	logic        rsp_exc, drying = 1'b0, code_protect = 1'b0, upd_valid = 1'b0, upd_ready;
	logic        wr_event, param_lock;
	logic [7:0]  req_func, rsp_func;
	logic [15:0] req_addr, req_data, rsp_data, wr_value, st = 16'h0000, upd_data = 16'h0000;
	logic [1:0]  upd_group = 2'h0, wr_group;
	logic [5:0]  upd_index = 6'h00, wr_index;
	int          n_mismatch = 0, n_checks = 0, cyc = 0, n_wr = 0, stall = 0;

	always #12.5 clk = ~clk;

	drive_status_param_regmap #(.ACCESS_CODE(CODE)) drive_status_param_regmap_i (
		.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req_func(req_func), .req_addr(req_addr), .req_data(req_data),
		.req_xfer_err(req_xfer_err), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
		.rsp_exc(rsp_exc), .rsp_func(rsp_func), .rsp_data(rsp_data),
		.drive_running(st[0]), .panel_setpoint(st[1]), .drive_blocked(st[2]),
		.restart_ready(st[3]), .restart_count(st[6:4]), .eeprom_crc_err(st[7]),
		.fault_code(st[12:8]), .fault_is_warning(st[13]), .dir_left(st[14]),
		.ident_active(st[15]), .drying_active(drying), .code_protect(code_protect),
		.upd_valid(upd_valid), .upd_ready(upd_ready), .upd_group(upd_group),
		.upd_index(upd_index), .upd_data(upd_data), .wr_event(wr_event),
		.wr_group(wr_group), .wr_index(wr_index), .wr_value(wr_value), .param_lock(param_lock)
	);

	link_master link_master_i (
		.clk(clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc),
		.rsp_func(rsp_func), .rsp_data(rsp_data), .req_valid(req_valid), .req_func(req_func),
		.req_addr(req_addr), .req_data(req_data), .req_xfer_err(req_xfer_err),
		.rsp_ready(rsp_ready)
	);

	// ------------------------------------------------------------
	// Timeout sized well above the roughly 200 cycles of traffic
	// ------------------------------------------------------------
	always @(negedge clk) begin
		cyc++;
		if (wr_event === 1'b1)
			n_wr++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ------------------------------------------------------------
	// Transfer helpers; every answer must come exactly two cycles after taking
	// ------------------------------------------------------------
	task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
	                  input logic x, input logic [15:0] exp);
		logic        ex, rdy;
		logic [7:0]  rf;
		logic [15:0] rd;
		int          lat;
		link_master_i.xfer(f, a, d, 1'b0, stall, ex, rf, rd, lat, rdy);
		chk(16'(lat), 16'h0002);
		chk({15'h0000, rdy}, 16'h0000);
		chk({15'h0000, ex}, {15'h0000, x});
		chk({8'h00, rf}, {8'h00, f});
		chk(rd, exp);
	endtask

	task automatic rd_ok(input logic [15:0] a, input logic [15:0] exp);
		op(FUNC_READ, a, 16'h0000, 1'b0, exp);
	endtask

	task automatic wr_ok(input logic [15:0] a, input logic [15:0] d);
		op(FUNC_WRITE, a, d, 1'b0, d);
	endtask

	task automatic exc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
	                   input logic [7:0] code);
		op(f, a, d, 1'b1, {8'h00, code});
	endtask

	task automatic upd(input logic [1:0] g, input logic [5:0] i, input logic [15:0] d);
		upd_valid = 1'b1;
		upd_group = g;
		upd_index = i;
		upd_data = d;
		while (upd_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		upd_valid = 1'b0;
		upd_data = ~d;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk({15'h0000, param_lock}, {15'h0000, LOCK_RESET});
		chk({15'h0000, rsp_valid}, 16'h0000);
		chk({14'h0000, req_ready, upd_ready}, 16'h0003);
	endtask

	task automatic t_state();
		logic [15:0] p;
		for (int i = 0; i < 17; i++) begin
			p = (i == 16) ? 16'hA5C3 : 16'h0001 << i;
			st = p;
			stall = i % 3;
			rd_ok(OP_STATE_ADDR, p);
		end
		stall = 0;
		st = 16'h0000;
	endtask

	task automatic t_supp();
		st = 16'hFFFF;
		drying = 1'b1;
		rd_ok(SUPP_STATE_ADDR, 16'h0002);
		drying = 1'b0;
		rd_ok(SUPP_STATE_ADDR, 16'h0000);
		st = 16'h0000;
	endtask

	task automatic t_group0();
		upd(2'h0, 6'h03, 16'h1357);
		rd_ok(GROUP0_BASE + 16'h0003, 16'h1357);
		exc(FUNC_WRITE, GROUP0_BASE + 16'h0003, 16'h0001, EXC_ADDR);
		rd_ok(GROUP0_BASE + 16'h0003, 16'h1357);
		exc(FUNC_WRITE, OP_STATE_ADDR, 16'h0000, EXC_ADDR);
	endtask

	task automatic t_group12();
		int w;
		w = n_wr;
		wr_ok(GROUP1_BASE + 16'h0014, 16'h0ABC);
		chk(16'(n_wr - w), 16'h0001);
		chk({14'h0000, wr_group}, 16'h0001);
		chk({10'h000, wr_index}, 16'h0014);
		chk(wr_value, 16'h0ABC);
		rd_ok(GROUP1_BASE + 16'h0014, 16'h0ABC);
		wr_ok(GROUP2_BASE + 16'h0001, PARAM_MAX_DEF);
		rd_ok(GROUP2_BASE + 16'h0001, PARAM_MAX_DEF);
		exc(FUNC_WRITE, GROUP2_BASE + 16'h0001, PARAM_MAX_DEF + 16'h0001, EXC_VALUE);
		rd_ok(GROUP2_BASE + 16'h0001, PARAM_MAX_DEF);
	endtask

	task automatic t_bad();
		logic [7:0]  fl [4] = '{8'h00, 8'h01, 8'h04, 8'h10};
		logic        ex, rdy;
		logic [7:0]  rf;
		logic [15:0] rd;
		int          lat, w;
		foreach (fl[i])
			exc(fl[i], OP_STATE_ADDR, 16'h0000, EXC_FUNC);
		exc(FUNC_READ, 16'h0000, 16'h0000, EXC_ADDR);
		exc(FUNC_READ, GROUP1_BASE + 16'h0040, 16'h0000, EXC_ADDR);
		w = n_wr;
		link_master_i.xfer(FUNC_WRITE, GROUP1_BASE + 16'h0014, 16'h0555, 1'b1, 0, ex, rf, rd, lat, rdy);
		chk(16'(lat), 16'h0000);
		chk({15'h0000, rdy}, 16'h0001);
		chk(16'(n_wr - w), 16'h0000);
		rd_ok(GROUP1_BASE + 16'h0014, 16'h0ABC);
	endtask

	task automatic t_lock();
		wr_ok(LOCK_ADDR, 16'h0001);
		chk({15'h0000, param_lock}, 16'h0001);
		rd_ok(LOCK_ADDR, 16'h0001);
		exc(FUNC_WRITE, GROUP2_BASE + 16'h0001, 16'h0022, EXC_REFUSED);
		rd_ok(GROUP2_BASE + 16'h0001, PARAM_MAX_DEF);
		exc(FUNC_WRITE, LOCK_ADDR, 16'h0002, EXC_VALUE);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		wr_ok(LOCK_ADDR, 16'h0001);
		wr_ok(LOCK_ADDR, 16'h0000);
		wr_ok(GROUP2_BASE + 16'h0001, 16'h0022);
	endtask

	task automatic t_code();
		code_protect = 1'b1;
		exc(FUNC_WRITE, GROUP2_BASE + 16'h0001, 16'h0033, EXC_REFUSED);
		wr_ok(CODE_ADDR, CODE - 16'h0001);
		exc(FUNC_WRITE, GROUP1_BASE + 16'h0014, 16'h0033, EXC_REFUSED);
		wr_ok(CODE_ADDR, CODE);
		rd_ok(CODE_ADDR, 16'h0000);
		wr_ok(GROUP2_BASE + 16'h0001, 16'h0033);
		wr_ok(CODE_ADDR, 16'h0000);
		exc(FUNC_WRITE, GROUP2_BASE + 16'h0001, 16'h0044, EXC_REFUSED);
		code_protect = 1'b0;
		wr_ok(GROUP2_BASE + 16'h0001, 16'h0044);
	endtask

	task automatic t_stop();
		st = 16'h0001;
		exc(FUNC_WRITE, GROUP1_BASE + 16'h0005, 16'h0001, EXC_REFUSED);
		exc(FUNC_WRITE, GROUP1_BASE + 16'h000F, 16'h0001, EXC_REFUSED);
		wr_ok(GROUP1_BASE + 16'h0010, 16'h0002);
		wr_ok(GROUP2_BASE + 16'h0005, 16'h0003);
		st = 16'h0000;
		wr_ok(GROUP1_BASE + 16'h0005, 16'h0004);
		rd_ok(GROUP1_BASE + 16'h0005, 16'h0004);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_state();
		t_supp();
		t_group0();
		t_group12();
		t_bad();
		t_lock();
		t_code();
		t_stop();
		end_sim();
	end
endmodule

`default_nettype wire
